// ===== design/mem_port_pkg.sv
// Package: register map, field layout and timing constants of the memory port
package mem_port_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_LIMITS  = 8'h00; // lower, upper, base limits
   localparam logic [7:0] OFF_OPTIONS = 8'h04; // option code, bank select
   localparam logic [7:0] OFF_STATUS  = 8'h08; // sticky event bits, w1c except the refresh timeout bit
   localparam logic [7:0] OFF_MASK    = 8'h0c; // interrupt mask
   localparam logic [7:0] OFF_STATE   = 8'h10; // live indications

   // Field positions
   localparam int LIM_LOWER_LSB = 0;
   localparam int LIM_UPPER_LSB = 8;
   localparam int LIM_BASE_LSB  = 16;
   localparam int OPT_MODE_LSB  = 0;
   localparam int OPT_SPEEDUP   = 2;
   localparam int OPT_WPARITY   = 3;
   localparam int OPT_BANK_LSB  = 4;

   // Status bit positions
   localparam int ST_REFRESH_TO = 0;
   localparam int ST_PARITY_ERR = 1;
   localparam int ST_REJECTED   = 2;
   localparam int ST_ACCEPTED   = 3;
   localparam int NUM_EVENTS    = 4;

   // Reset values
   localparam logic [31:0] LIMITS_RST  = 32'h0000_ff00;
   localparam logic [7:0]  OPTIONS_RST = 8'h00;

   // Address: one limit count covers 64K words
   localparam int ADDR_W      = 24;
   localparam int LIMIT_SHIFT = 16;

   // Interleave modes
   typedef enum logic [1:0] {
      IL_NONE = 2'h0,
      IL_2WAY = 2'h1,
      IL_4WAY = 2'h2,
      IL_8WAY = 2'h3
   } ilv_mode_e;

   // Address settling when speedup is off, least time rounded up
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_NS     = 40;
   localparam int SETTLE_CYC    =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Port controller states, Gray along the usual path
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SETTLE = 2'b01,
      ST_REQ    = 2'b11,
      ST_CYCLE  = 2'b10
   } port_state_e;

   // Request from the channel
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              write;
      logic [15:0]       data;
      logic [1:0]        par;
   } chan_req_s;

   // Memory cycle issued to the shared memory
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              write;
      logic [15:0]       data;
   } mem_cyc_s;

endpackage : mem_port_pkg

// ===== design/mem_port_window_interleave.sv
// Memory port with window decode, interleave bank select and status
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module mem_port_window_interleave
   import mem_port_pkg::*;
(
   input  wire logic        clk,                    // 100 MHz clock
   input  wire logic        rst,                    // Async reset, high
   input  wire logic        master_clear,           // Master clear pulse
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,           // Write address
   input  wire logic        s_axi_awvalid,          // Write address valid
   output logic             s_axi_awready,          // Write address ready
   input  wire logic [31:0] s_axi_wdata,            // Write data
   input  wire logic [3:0]  s_axi_wstrb,            // Write byte strobes
   input  wire logic        s_axi_wvalid,           // Write data valid
   output logic             s_axi_wready,           // Write data ready
   output logic [1:0]       s_axi_bresp,            // Write response
   output logic             s_axi_bvalid,           // Write response valid
   input  wire logic        s_axi_bready,           // Write response ready
   input  wire logic [7:0]  s_axi_araddr,           // Read address
   input  wire logic        s_axi_arvalid,          // Read address valid
   output logic             s_axi_arready,          // Read address ready
   output logic [31:0]      s_axi_rdata,            // Read data
   output logic [1:0]       s_axi_rresp,            // Read response
   output logic             s_axi_rvalid,           // Read data valid
   input  wire logic        s_axi_rready,           // Read data ready
   // Channel side
   input  wire logic        channel_request_strobe, // Request pulse
   input  wire chan_req_s   chan_req,               // Request payload
   output logic             address_accepted_flag,  // Address OK level
   output logic             chan_done,              // Access finished pulse
   // Shared memory side
   output logic             mem_req,                // Cycle request level
   output mem_cyc_s         mem_cyc,                // Cycle payload
   input  wire logic        mem_grant,              // Cycle allocated
   input  wire logic        mem_done,               // Cycle finished pulse
   input  wire logic        refresh_timeout,        // Refresh timeout pulse
   output logic             granted,                // Granted indication
   output logic             refresh_to_flag,        // Sticky timeout status
   output logic             parity_error,           // Parity error pulse
   output logic             irq                     // Interrupt level
);

   // Register state
   logic [31:0]           limits_r, limits_nxt;
   logic [7:0]            options_r, options_nxt;
   logic [NUM_EVENTS-1:0] status_r, status_nxt, mask_r, mask_nxt;
   logic                  irq_r, irq_nxt;
   // Bus state
   logic       awready_r, awready_nxt, wready_r, wready_nxt;
   logic       arready_r, arready_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic       bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   // Port state
   port_state_e state_r, state_nxt;
   logic [1:0]  settle_r, settle_nxt;
   chan_req_s   req_r, req_nxt;
   mem_cyc_s    cyc_r, cyc_nxt;
   logic        address_accepted_flag_r, address_accepted_flag_nxt, grant_r, grant_nxt, rto_r, rto_nxt;
   logic        perr_r, perr_nxt, done_r, done_nxt, mreq_r, mreq_nxt;

   // Decoded settings
   logic [ADDR_W-1:0] lower_addr, upper_addr;
   ilv_mode_e   mode;
   logic        speedup, wparity;
   logic [2:0]  bank_sel, bank_mask;
   logic        in_window, bank_hit, par_bad;
   logic [NUM_EVENTS-1:0] ev;
   logic        wr_fire, rd_fire;

   // Option and window decode
   always_comb
   begin
      lower_addr = ADDR_W'({limits_r[LIM_LOWER_LSB +: 8], 16'h0000});
      upper_addr = ADDR_W'({limits_r[LIM_UPPER_LSB +: 8], 16'h0000});
      mode       = ilv_mode_e'(options_r[OPT_MODE_LSB +: 2]);
      speedup    = options_r[OPT_SPEEDUP];
      wparity    = options_r[OPT_WPARITY];
      bank_sel   = options_r[OPT_BANK_LSB +: 3];
      case (mode)
         IL_NONE: bank_mask = 3'h0;
         IL_2WAY: bank_mask = 3'h1;
         IL_4WAY: bank_mask = 3'h3;
         IL_8WAY: bank_mask = 3'h7;
         default: bank_mask = 3'h0;
      endcase
      in_window = (req_r.addr >= lower_addr)
               && (req_r.addr < upper_addr);
      bank_hit  = ((req_r.addr[2:0] ^ bank_sel) & bank_mask) == 3'h0;
      // Odd parity per byte: data bits plus parity bit must be odd
      par_bad   = req_r.write && wparity
               && (!(^{req_r.data[7:0], req_r.par[0]})
                || !(^{req_r.data[15:8], req_r.par[1]}));
   end

   // Port controller next state
   always_comb
   begin
      state_nxt = state_r;
      settle_nxt = settle_r;
      req_nxt = req_r;
      cyc_nxt = cyc_r;
      address_accepted_flag_nxt = address_accepted_flag_r;
      grant_nxt = mem_grant && mreq_r;
      perr_nxt = 1'b0;
      done_nxt = 1'b0;
      mreq_nxt = mreq_r;
      rto_nxt = (rto_r & !master_clear) | refresh_timeout;
      if (channel_request_strobe)
         address_accepted_flag_nxt = 1'b0;
      case (state_r)
         ST_IDLE:
            if (channel_request_strobe)
            begin
               req_nxt = chan_req;
               settle_nxt = 2'(SETTLE_CYC - 1);
               state_nxt = speedup ? ST_REQ : ST_SETTLE;
            end
         ST_SETTLE:
         begin
            req_nxt = chan_req;
            if (settle_r == 2'h0)
               state_nxt = ST_REQ;
            else
               settle_nxt = settle_r - 2'h1;
         end
         ST_REQ:
            if (in_window && bank_hit)
            begin
               address_accepted_flag_nxt = 1'b1;
               perr_nxt = par_bad;
               cyc_nxt.addr = req_r.addr;
               cyc_nxt.write = req_r.write;
               cyc_nxt.data = req_r.data;
               mreq_nxt = 1'b1;
               state_nxt = ST_CYCLE;
            end
            else
               state_nxt = ST_IDLE;
         ST_CYCLE:
            if (mem_done)
            begin
               mreq_nxt = 1'b0;
               done_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Events into the sticky status
   always_comb
   begin
      ev[ST_REFRESH_TO] = refresh_timeout;
      ev[ST_PARITY_ERR] = perr_nxt;
      ev[ST_REJECTED]   = (state_r == ST_REQ) && !(in_window && bank_hit);
      ev[ST_ACCEPTED]   = (state_r == ST_REQ) && in_window && bank_hit;
   end

   // AXI4-Lite slave next state and register writes
   always_comb
   begin
      awready_nxt = awready_r;
      wready_nxt = wready_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      limits_nxt = limits_r;
      options_nxt = options_r;
      mask_nxt = mask_r;
      status_nxt = status_r;
      wr_fire = !awready_r && !wready_r && !bvalid_r;
      rd_fire = s_axi_arvalid && arready_r;
      if (s_axi_awvalid && awready_r)
      begin
         awready_nxt = 1'b0;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r)
      begin
         wready_nxt = 1'b0;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         awready_nxt = 1'b1;
         wready_nxt = 1'b1;
         bvalid_nxt = 1'b1;
         bresp_nxt = 2'h0;
         case ({awaddr_r[7:2], 2'h0})
            OFF_LIMITS:
               for (int i = 0; i < 3; i++)
                  if (wstrb_r[i])
                     limits_nxt[8*i +: 8] = wdata_r[8*i +: 8];
            OFF_OPTIONS: if (wstrb_r[0])
               options_nxt = {1'b0, wdata_r[6:0]};
            OFF_STATUS: if (wstrb_r[0])
               status_nxt = status_r & ~wdata_r[NUM_EVENTS-1:0];
            OFF_MASK: if (wstrb_r[0])
               mask_nxt = wdata_r[NUM_EVENTS-1:0];
            OFF_STATE: ;
            default: bresp_nxt = 2'h2;
         endcase
      end
      else if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
      // Timeout bit may only leave on master clear
      status_nxt[ST_REFRESH_TO] = status_r[ST_REFRESH_TO]
                                & !master_clear;
      status_nxt = status_nxt | ev;                                  // Set wins
      if (rd_fire)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = 2'h0;
         case ({s_axi_araddr[7:2], 2'h0})
            OFF_LIMITS:  rdata_nxt = {8'h00, limits_r[23:0]};
            OFF_OPTIONS: rdata_nxt = {24'h0, options_r};
            OFF_STATUS:  rdata_nxt = {28'h0, status_r};
            OFF_MASK:    rdata_nxt = {28'h0, mask_r};
            OFF_STATE:   rdata_nxt = {26'h0, state_r, grant_r, mreq_r,
                                      rto_r, address_accepted_flag_r};
            default:
            begin
               rdata_nxt = 32'h0;
               rresp_nxt = 2'h2;
            end
         endcase
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_nxt = 1'b0;
      arready_nxt = !rvalid_nxt;
      irq_nxt = |(status_nxt & mask_nxt);
   end

   // Registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         limits_r <= LIMITS_RST;
         options_r <= OPTIONS_RST;
         status_r <= '0;
         mask_r <= '0;
         irq_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         arready_r <= 1'b1;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         rvalid_r <= 1'b0;
         rresp_r <= 2'h0;
         rdata_r <= 32'h0;
         state_r <= ST_IDLE;
         settle_r <= 2'h0;
         req_r <= '0;
         cyc_r <= '0;
         address_accepted_flag_r <= 1'b0;
         grant_r <= 1'b0;
         rto_r <= 1'b0;
         perr_r <= 1'b0;
         done_r <= 1'b0;
         mreq_r <= 1'b0;
      end
      else
      begin
         limits_r <= limits_nxt;
         options_r <= options_nxt;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         arready_r <= arready_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         state_r <= state_nxt;
         settle_r <= settle_nxt;
         req_r <= req_nxt;
         cyc_r <= cyc_nxt;
         address_accepted_flag_r <= address_accepted_flag_nxt;
         grant_r <= grant_nxt;
         rto_r <= rto_nxt;
         perr_r <= perr_nxt;
         done_r <= done_nxt;
         mreq_r <= mreq_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign address_accepted_flag = address_accepted_flag_r;
   assign chan_done = done_r;
   assign mem_req = mreq_r;
   assign mem_cyc = cyc_r;
   assign granted = grant_r;
   assign refresh_to_flag = rto_r;
   assign parity_error = perr_r;
   assign irq = irq_r;

endmodule : mem_port_window_interleave

// ===== test/mem_port_monitor.sv
// Concurrent checks on the memory port pins
`timescale 1ns/100ps
module mem_port_monitor
   import mem_port_pkg::*;
(
   input wire logic     clk,                    // Clock
   input wire logic     rst,                    // Async reset
   input wire logic     master_clear,           // Master clear
   input wire logic     channel_request_strobe, // Request pulse
   input wire logic     address_accepted_flag,  // Address OK
   input wire logic     chan_done,              // Access end
   input wire logic     mem_req,                // Cycle request
   input wire mem_cyc_s mem_cyc,                // Cycle payload
   input wire logic     mem_grant,              // Arbiter grant
   input wire logic     mem_done,               // Cycle end
   input wire logic     refresh_timeout,        // Timeout pulse
   input wire logic     granted,                // Grant shown
   input wire logic     refresh_to_flag,        // Sticky timeout
   input wire logic     parity_error            // Parity pulse
);
   // One clock domain, checks off during reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_grant_shown: assert property (mem_grant && mem_req |=> granted)
      else $error("grant not shown");
   a_grant_quiet: assert property (!mem_req |=> !granted)
      else $error("grant without cycle");
   a_timeout_set: assert property
      (refresh_timeout |=> refresh_to_flag)
      else $error("timeout not flagged");
   a_timeout_cause: assert property
      ($changed(refresh_to_flag) |-> $past(refresh_timeout)
       || $past(master_clear))
      else $error("timeout flag moved alone");
   a_timeout_clear: assert property
      (master_clear && !refresh_timeout |=> !refresh_to_flag)
      else $error("timeout not cleared");
   a_flag_drop: assert property
      (channel_request_strobe |=> !address_accepted_flag)
      else $error("flag kept over request");
   a_flag_stay: assert property
      (address_accepted_flag && !channel_request_strobe && !master_clear
       |=> address_accepted_flag)
      else $error("flag dropped early");
   a_cycle_flagged: assert property
      ($rose(mem_req) |-> address_accepted_flag)
      else $error("cycle without accept");
   a_cycle_held: assert property
      (mem_req && !mem_done |=> mem_req && $stable(mem_cyc))
      else $error("cycle changed early");
   a_cycle_ends: assert property
      (mem_req && mem_done |=> !mem_req && chan_done)
      else $error("cycle end wrong");
   a_parity_time: assert property
      (parity_error |-> $rose(mem_req) && mem_cyc.write)
      else $error("parity error out of place");
endmodule : mem_port_monitor

bind mem_port_window_interleave mem_port_monitor u_mon (
   .clk, .rst, .master_clear, .channel_request_strobe,
   .address_accepted_flag, .chan_done, .mem_req, .mem_cyc, .mem_grant,
   .mem_done, .refresh_timeout, .granted, .refresh_to_flag, .parity_error
);

// ===== test/chan_requester.sv
// Requester model on the channel side of the port
`timescale 1ns/100ps
module chan_requester
   import mem_port_pkg::*;
(
   input  wire logic clk,                    // Bench clock
   output chan_req_s chan_req,               // Request payload
   output logic      channel_request_strobe  // Request pulse
);
   // Idle lines before the first request
   initial
   begin
      chan_req = '0;
      channel_request_strobe = 1'b0;
   end

   // Payload, then a one-cycle strobe; payload early when fast
   task automatic issue(input logic [23:0] a, input logic w,
                        input logic [15:0] d, input logic early,
                        input logic bad);
      chan_req_s r;
      r.addr = a;
      r.write = w;
      r.data = d;
      r.par = {~^d[15:8], ~^d[7:0] ^ bad};
      chan_req <= r;
      if (early)
         repeat (4) @(posedge clk);
      channel_request_strobe <= 1'b1;
      @(posedge clk);
      channel_request_strobe <= 1'b0;
   endtask : issue

   // Released lines show the inverse of the last payload
   task automatic release_bus();
      chan_req <= ~chan_req;
   endtask : release_bus
endmodule : chan_requester

// ===== test/memory_port_window_interleave_bench.sv
// Self-checking bench for the memory port window and interleave logic
`timescale 1ns/100ps
module memory_port_window_interleave_bench
   import mem_port_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, master_clear = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic [3:0]  s_axi_wstrb = 4'hf, msk;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, mem_grant = 1'b0, mem_done = 1'b0;
   logic        refresh_timeout = 1'b0, channel_request_strobe;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, address_accepted_flag, chan_done, mem_req;
   logic        granted, refresh_to_flag, parity_error, irq, sp, wp;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r, md;
   logic [7:0]  lo, up, bs;
   logic [2:0]  bk;
   logic [6:0]  opt;
   logic [23:0] a;
   chan_req_s   chan_req;
   mem_cyc_s    mem_cyc;
   int          n_mismatch = 0, n_tests = 0, cyc = 0;

   mem_port_window_interleave u_dut (
      .clk, .rst, .master_clear, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_request_strobe,
      .chan_req, .address_accepted_flag, .chan_done, .mem_req, .mem_cyc,
      .mem_grant, .mem_done, .refresh_timeout, .granted, .refresh_to_flag,
      .parity_error, .irq
   );
   chan_requester u_req (.clk, .chan_req, .channel_request_strobe);

   // Clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   function automatic void chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endfunction : chk

   // Expected window and bank decision
   function automatic logic hit(input logic [23:0] x);
      logic [2:0] m;
      m = 3'((4'h1 << md) - 4'h1);
      return x >= {lo, 16'h0} && x < {up, 16'h0}
             && ((x[2:0] ^ bk) & m) == 3'h0;
   endfunction : hit

   // One register access, write or read
   task automatic bus(input logic wr, input logic [7:0] ad,
                      input logic [31:0] d, output logic [31:0] rq,
                      output logic [1:0] rr);
      @(posedge clk);
      s_axi_awaddr <= ad;
      s_axi_araddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      do
      begin
         @(posedge clk);
         s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
         s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      end
      while (!(wr ? s_axi_bvalid : s_axi_rvalid));
      rq = s_axi_rdata;
      rr = wr ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask : bus

   // One channel request, memory cycle and event status
   task automatic req(input logic [23:0] x);
      logic        w, bad, e, pe;
      logic [15:0] d;
      int          k;
      w = 1'($urandom);
      d = 16'($urandom);
      bad = 1'($urandom);
      e = hit(x);
      pe = e && wp && w && bad;
      @(posedge clk);
      u_req.issue(x, w, d, sp, bad);
      k = 0;
      do
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (mem_req !== 1'b1 && k < 10);
      chk(mem_req === e, "window decision");
      if (e)
      begin
         chk(k == (sp ? 1 : SETTLE_CYC + 1), "start delay");
         chk(address_accepted_flag === 1'b1, "accept flag");
         chk(mem_cyc.addr === x && mem_cyc.write === w, "cycle");
         chk(parity_error === pe, "write parity");
         chk(mem_cyc.data === d, "cycle data");
         chk(granted === 1'b0, "no grant yet");
         @(posedge clk);
         mem_grant <= 1'b1;
         repeat ($urandom_range(1, 3)) @(posedge clk);
         mem_done <= 1'b1;
         @(posedge clk);
         mem_done <= 1'b0;
         mem_grant <= 1'b0;
         #1;
         chk(chan_done === 1'b1 && granted === 1'b1, "cycle end");
      end
      else
         chk(address_accepted_flag === 1'b0, "refused");
      u_req.release_bus();
      bus(0, OFF_STATUS, 0, q, r);
      chk(q[3:1] === {e, !e, pe}, "event status");
      chk(irq === |({e, !e, pe} & msk[3:1]), "irq level");
      bus(1, OFF_STATUS, 32'he, q, r);
      bus(0, OFF_STATUS, 0, q, r);
      chk(q[3:1] === 3'h0 && irq === 1'b0, "status clear");
   endtask : req

   // Main sequence
   initial
   begin
      void'($urandom(32'h86cb04c4));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(0, OFF_LIMITS, 0, q, r);
      chk(q === LIMITS_RST && r === 2'h0, "limits reset");
      bus(0, OFF_OPTIONS, 0, q, r);
      chk(q[7:0] === OPTIONS_RST, "options reset");
      bus(0, 8'h14, 0, q, r);
      chk(q === 32'h0 && r === 2'h2, "unmapped read");
      bus(1, 8'h14, 32'hffffffff, q, r);
      chk(r === 2'h2, "unmapped write");
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         md = i[1:0];
         sp = i[2];
         wp = i[2] ^ i[0];
         bk = 3'($urandom);
         msk = 4'($urandom);
         lo = 8'($urandom_range(0, 8));
         up = lo + 8'($urandom_range(1, 8));
         opt = {bk, wp, sp, md};
         bs = 8'($urandom);
         bus(1, OFF_LIMITS, {8'h0, bs, up, lo}, q, r);
         bus(1, OFF_OPTIONS, {25'h0, opt}, q, r);
         bus(1, OFF_MASK, {28'h0, msk}, q, r);
         bus(0, OFF_LIMITS, 0, q, r);
         chk(q === {8'h0, bs, up, lo}, "limits readback");
         bus(0, OFF_OPTIONS, 0, q, r);
         chk(q[6:0] === opt, "options readback");
         for (int j = 0; j < 6; j++)
         begin
            a = {8'(lo + $urandom_range(0, up - lo + 1) - 1),
                 16'($urandom)};
            if (j[0])
               a[2:0] = bk;
            if (j == 0)
               a = {up, 16'h0} - 24'h8 + 24'(bk);
            if (j == 2)
               a = {lo, 16'h0} + 24'(bk);
            if (j == 4)
               a = {up, 16'h0} + 24'(bk);
            req(a);
         end
         $display("test window %0d done", i);
      end
      // Sticky refresh timeout, cleared only by master clear
      @(posedge clk);
      refresh_timeout <= 1'b1;
      @(posedge clk);
      refresh_timeout <= 1'b0;
      bus(1, OFF_STATUS, 32'h1, q, r);
      bus(0, OFF_STATUS, 0, q, r);
      chk(q[0] === 1'b1 && refresh_to_flag === 1'b1, "sticky");
      bus(0, OFF_STATE, 0, q, r);
      chk(q[5:1] === {ST_IDLE, 3'h1}, "state view");
      @(posedge clk);
      master_clear <= 1'b1;
      @(posedge clk);
      master_clear <= 1'b0;
      bus(0, OFF_STATUS, 0, q, r);
      chk(q[0] === 1'b0 && refresh_to_flag === 1'b0, "cleared");
      $display("test refresh done");
      end_sim();
   end
endmodule : memory_port_window_interleave_bench
